// ==== rtu_consts.svh ====
// Constants for the receiver training policy and unplug detection block
// Functional notes
// - Equalization option 00 steps pre-emphasis request up each iteration to the maximum.
// - Equalization option 01 holds pre-emphasis request at the maximum level.
// - Equalization option 11 reads pre-emphasis per iteration from the table; 10 invalid.
// - Fixed swing level field sits at bits 9 to 8, resets to zero.
// - Swing step interval field at bits 6 to 4 sets iterations between swing steps.
// - Recovery option 00 steps swing request up every iteration.
// - Recovery option 01 steps swing every four or every step-interval iterations.
// - Recovery option 10 holds swing at the fixed level; 11 invalid.
// - Minimum swing field at bits 1 to 0, encoded like lane drive setting.
// - Bit 30 of lock control disables the training timeout.
// - Twenty-bit lock timeout counter on bus clock, default 0x1388.
// - Thirty-two-bit idle limit register defaults to 0x1312d00.
// - Unplug interrupt raised when no blanking start arrives within idle limit.
// - Unplug counter free runs, reloads on blanking start or on timeout.
// - Training forced to fail until lane swing setting meets the minimum.
// - Pre-emphasis table holds five two-bit levels, bits 14 to 23.
`ifndef RTU_CONSTS_SVH
`define RTU_CONSTS_SVH
`define RTU_OFF_POLICY      12'h214
`define RTU_OFF_LOCK        12'h21c
`define RTU_OFF_IDLE        12'h220
`define RTU_IDLE_RST        32'h01312d00
`define RTU_LOCK_RST        20'h01388
`define RTU_POLICY_RST      32'h00000000
`define RTU_LOCK_DIS_BIT    30
`define RTU_LOCK_MSB        19
`define RTU_TBL_LSB         14
`define RTU_MAXPE_LSB       12
`define RTU_EQOPT_LSB       10
`define RTU_FIXSW_LSB       8
`define RTU_STEP_LSB        4
`define RTU_CROPT_LSB       2
`define RTU_MINSW_LSB       0
`define RTU_TBL_ENTRIES     5
`define RTU_DEF_STEP        3'h4
`define RTU_LVL_MAX         2'h3
`endif

// ==== rtu_pkg.sv ====
// Types for the receiver training policy and unplug detection block
package rtu_pkg;
    typedef enum logic [1:0] {
        RTU_EQ_STEP  = 2'h0,
        RTU_EQ_HOLD  = 2'h1,
        RTU_EQ_BAD   = 2'h2,
        RTU_EQ_TABLE = 2'h3
    } rtu_eq_opt_t;
    typedef enum logic [1:0] {
        RTU_CR_STEP  = 2'h0,
        RTU_CR_SLOW  = 2'h1,
        RTU_CR_HOLD  = 2'h2,
        RTU_CR_BAD   = 2'h3
    } rtu_cr_opt_t;
    typedef enum logic [2:0] {
        RTU_ST_IDLE  = 3'h1,
        RTU_ST_TRAIN = 3'h2,
        RTU_ST_FAIL  = 3'h4
    } rtu_state_t;
endpackage : rtu_pkg

// ==== rtu_top.sv ====
// Receiver training adjust policy, lock timeout and cable unplug detection
`timescale 1ns/1ps
`include "rtu_consts.svh"
module rtu_top
    import rtu_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Register port
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    // Training link events
    input  wire logic        TRAIN_START,
    input  wire logic        TRAIN_ITER,
    input  wire logic        LOCK_ACQUIRED,
    input  wire logic [1:0]  LANE_SWING_SET,
    // Main link symbol pin
    input  wire logic        BLANK_START_PIN,
    // Results
    output logic [1:0]       PREEMPH_REQ,
    output logic [1:0]       SWING_REQ,
    output logic             TRAIN_FAIL,
    output logic             LOCK_TIMEOUT,
    output logic             UNPLUG_IRQ
);
    logic [31:0] policy_q;
    logic [31:0] lock_ctl_q;
    logic [31:0] idle_limit_q;
    logic [31:0] idle_cnt_q;
    logic [19:0] lock_cnt_q;
    logic [2:0]  iter_q;
    logic [2:0]  step_cnt_q;
    logic [1:0]  pe_q;
    logic [1:0]  sw_q;
    logic [2:0]  bs_sync_q;
    logic        lock_to_q;
    logic        irq_q;
    rtu_state_t  state_q;

    rtu_eq_opt_t eq_opt;
    rtu_cr_opt_t cr_opt;
    logic [1:0]  max_pe;
    logic [1:0]  fix_sw;
    logic [1:0]  min_sw;
    logic [2:0]  step_int;
    logic [2:0]  step_lim;
    logic [1:0]  tbl_pe;
    logic        bs_rise;
    logic        iter_ev;

    assign eq_opt   = rtu_eq_opt_t'(policy_q[`RTU_EQOPT_LSB +: 2]);
    assign cr_opt   = rtu_cr_opt_t'(policy_q[`RTU_CROPT_LSB +: 2]);
    assign max_pe   = policy_q[`RTU_MAXPE_LSB +: 2];
    assign fix_sw   = policy_q[`RTU_FIXSW_LSB +: 2];
    assign step_int = policy_q[`RTU_STEP_LSB +: 3];
    assign min_sw   = policy_q[`RTU_MINSW_LSB +: 2];
    // Zero interval falls back to the default step of four
    assign step_lim = (step_int == 3'h0) ? `RTU_DEF_STEP : step_int;
    // Iterations past the fifth keep the last table entry
    assign tbl_pe   = policy_q[`RTU_TBL_LSB + 2 * ((iter_q < `RTU_TBL_ENTRIES) ? iter_q : 3'h4) +: 2];
    assign iter_ev  = TRAIN_ITER && (state_q == RTU_ST_TRAIN);

    // Register writes
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            policy_q     <= `RTU_POLICY_RST;
            lock_ctl_q   <= {12'h000, `RTU_LOCK_RST};
            idle_limit_q <= `RTU_IDLE_RST;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `RTU_OFF_POLICY: policy_q     <= REG_WDATA;
                `RTU_OFF_LOCK:   lock_ctl_q   <= REG_WDATA;
                `RTU_OFF_IDLE:   idle_limit_q <= REG_WDATA;
                default: begin
                end
            endcase
        end
    end

    // Register reads, registered one cycle after the strobe
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `RTU_OFF_POLICY: REG_RDATA <= policy_q;
                `RTU_OFF_LOCK:   REG_RDATA <= lock_ctl_q;
                `RTU_OFF_IDLE:   REG_RDATA <= idle_limit_q;
                default:         REG_RDATA <= 32'h00000000;
            endcase
        end
    end

    // Training state
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= RTU_ST_IDLE;
        end else begin
            case (state_q)
                RTU_ST_IDLE: begin
                    if (TRAIN_START) begin
                        state_q <= RTU_ST_TRAIN;
                    end
                end
                RTU_ST_TRAIN: begin
                    if (TRAIN_START) begin
                        state_q <= RTU_ST_TRAIN;
                    end else if (lock_to_q) begin
                        state_q <= RTU_ST_FAIL;
                    end else if (LOCK_ACQUIRED && LANE_SWING_SET >= min_sw) begin
                        state_q <= RTU_ST_IDLE;
                    end
                end
                RTU_ST_FAIL: begin
                    if (TRAIN_START) begin
                        state_q <= RTU_ST_TRAIN;
                    end
                end
                default: state_q <= RTU_ST_IDLE;
            endcase
        end
    end

    // Iteration counters
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            iter_q     <= 3'h0;
            step_cnt_q <= 3'h0;
        end else if (TRAIN_START) begin
            iter_q     <= 3'h0;
            step_cnt_q <= 3'h0;
        end else if (iter_ev) begin
            if (iter_q != 3'h7) begin
                iter_q <= iter_q + 3'h1;
            end
            step_cnt_q <= (step_cnt_q + 3'h1 >= step_lim) ? 3'h0 : step_cnt_q + 3'h1;
        end
    end

    // Pre-emphasis request
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pe_q <= 2'h0;
        end else if (TRAIN_START) begin
            case (eq_opt)
                RTU_EQ_HOLD:  pe_q <= max_pe;
                RTU_EQ_TABLE: pe_q <= policy_q[`RTU_TBL_LSB +: 2];
                default:      pe_q <= 2'h0;
            endcase
        end else if (iter_ev) begin
            case (eq_opt)
                RTU_EQ_STEP:  pe_q <= (pe_q < max_pe) ? pe_q + 2'h1 : max_pe;
                RTU_EQ_HOLD:  pe_q <= max_pe;
                RTU_EQ_TABLE: pe_q <= policy_q[`RTU_TBL_LSB + 2 * ((iter_q + 3'h1 < `RTU_TBL_ENTRIES)
                                      ? iter_q + 3'h1 : 3'h4) +: 2];
                default:      pe_q <= pe_q;
            endcase
        end
    end

    // Voltage swing request; steps stop at level 3, and the minimum swing field does not bound it
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sw_q <= 2'h0;
        end else if (TRAIN_START) begin
            sw_q <= (cr_opt == RTU_CR_HOLD) ? fix_sw : 2'h0;
        end else if (iter_ev) begin
            case (cr_opt)
                RTU_CR_STEP: begin
                    if (sw_q != `RTU_LVL_MAX) sw_q <= sw_q + 2'h1;
                end
                RTU_CR_SLOW: begin
                    if (step_cnt_q + 3'h1 >= step_lim && sw_q != `RTU_LVL_MAX) begin
                        sw_q <= sw_q + 2'h1;
                    end
                end
                RTU_CR_HOLD: sw_q <= fix_sw;
                default:     sw_q <= sw_q;
            endcase
        end
    end

    // Lock timeout counter; disable bit keeps the timeout flag low when it expires
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lock_cnt_q <= 20'h00000;
            lock_to_q  <= 1'b0;
        end else if (TRAIN_START || state_q != RTU_ST_TRAIN || LOCK_ACQUIRED) begin
            lock_cnt_q <= lock_ctl_q[`RTU_LOCK_MSB:0];
            lock_to_q  <= 1'b0;
        end else if (lock_cnt_q != 20'h00000) begin
            lock_cnt_q <= lock_cnt_q - 20'h00001;
            lock_to_q  <= 1'b0;
        end else begin
            lock_to_q  <= !lock_ctl_q[`RTU_LOCK_DIS_BIT];
        end
    end

    // Blanking start pin synchroniser; stages two and three compared
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bs_sync_q <= 3'h0;
        end else begin
            bs_sync_q <= {bs_sync_q[1:0], BLANK_START_PIN};
        end
    end
    assign bs_rise = bs_sync_q[1] && !bs_sync_q[2];

    // Free running unplug counter
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            idle_cnt_q <= `RTU_IDLE_RST;
            irq_q      <= 1'b0;
        end else if (bs_rise) begin
            idle_cnt_q <= idle_limit_q;
            irq_q      <= 1'b0;
        end else if (idle_cnt_q == 32'h00000000) begin
            idle_cnt_q <= idle_limit_q;
            irq_q      <= 1'b1;
        end else begin
            idle_cnt_q <= idle_cnt_q - 32'h00000001;
            irq_q      <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TRAIN_FAIL <= 1'b0;
        end else begin
            TRAIN_FAIL <= (state_q == RTU_ST_FAIL) ||
                          (state_q == RTU_ST_TRAIN && LANE_SWING_SET < min_sw);
        end
    end
    assign PREEMPH_REQ  = pe_q;
    assign SWING_REQ    = sw_q;
    assign LOCK_TIMEOUT = lock_to_q;
    assign UNPLUG_IRQ   = irq_q;
    // tbl_pe exposed via read-back is unnecessary; kept for table index reuse
    logic unused_tbl;
    assign unused_tbl = ^tbl_pe;
endmodule : rtu_top

// ==== rtu_assertions.sv ====
// Port-level checks for the training policy and unplug logic
`timescale 1ns/1ps
`include "rtu_consts.svh"
module rtu_assertions
    import rtu_pkg::*;
(
    // Clock, reset, register writes
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        REG_WR,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    // Link events
    input wire logic        TRAIN_START,
    input wire logic        TRAIN_ITER,
    input wire logic        LOCK_ACQUIRED,
    input wire logic [1:0]  LANE_SWING_SET,
    input wire logic        BLANK_START_PIN,
    // Results
    input wire logic [1:0]  PREEMPH_REQ,
    input wire logic [1:0]  SWING_REQ,
    input wire logic        TRAIN_FAIL,
    input wire logic        LOCK_TIMEOUT,
    input wire logic        UNPLUG_IRQ
);
    logic [31:0] pol_q;
    logic        dis_q;
    logic        trn_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Shadows of the writes and of a first start; iteration checks assume lock is not acquired while iterating
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pol_q <= 32'h0;
            dis_q <= 1'h0;
            trn_q <= 1'h0;
        end else begin
            if (REG_WR && REG_ADDR == `RTU_OFF_POLICY)
                pol_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == `RTU_OFF_LOCK)
                dis_q <= REG_WDATA[`RTU_LOCK_DIS_BIT];
            if (TRAIN_START)
                trn_q <= 1'h1;
        end
    end
    a_irq_one_cycle: assert property (UNPLUG_IRQ |=> !UNPLUG_IRQ)
        else $error("unplug pulse longer than one cycle");
    a_symbol_reloads: assert property ($rose(BLANK_START_PIN) |-> ##4 !UNPLUG_IRQ [*8])
        else $error("unplug raised right after a symbol");
    a_lock_disabled: assert property (dis_q && $past(dis_q) |-> !LOCK_TIMEOUT)
        else $error("timeout while disabled");
    a_locked_quiet: assert property (LOCK_ACQUIRED [*3] |-> !LOCK_TIMEOUT)
        else $error("timeout while locked");
    // Only the cycle right after a start is known to be in training from the ports alone
    a_min_swing: assert property ($past(TRAIN_START, 2) && !$past(TRAIN_START) && $stable(pol_q)
        && $past(LANE_SWING_SET) < pol_q[1:0]
        |-> TRAIN_FAIL)
        else $error("training not failed below minimum swing");
    a_pe_hold: assert property ($past(TRAIN_START) && $stable(pol_q) && pol_q[11:10] == RTU_EQ_HOLD
        |-> PREEMPH_REQ == pol_q[13:12])
        else $error("pre-emphasis not held at maximum");
    a_sw_hold: assert property ($past(TRAIN_START) && $stable(pol_q) && pol_q[3:2] == RTU_CR_HOLD
        |-> SWING_REQ == pol_q[9:8])
        else $error("swing not held at fixed level");
    a_pe_step: assert property ($past(TRAIN_ITER) && $past(trn_q) && !$past(TRAIN_START) && $stable(pol_q)
        && pol_q[11:10] == RTU_EQ_STEP |-> PREEMPH_REQ == ($past(PREEMPH_REQ) < pol_q[13:12] ?
        $past(PREEMPH_REQ) + 2'h1 : pol_q[13:12]))
        else $error("pre-emphasis step wrong");
endmodule : rtu_assertions
bind rtu_top rtu_assertions chk (.*);

// ==== rtu_src_model.sv ====
// Link transmitter model sending blanking start symbols at a fixed gap
`timescale 1ns/1ps
module rtu_src_model (
    // Clock and control
    input  wire logic CLK,
    input  wire logic en,
    input  wire logic [31:0] gap,
    // Link symbol
    output logic      blank_start = 1'h0
);
    int cnt = 0;
    // Two cycles high so the three-stage synchroniser cannot miss it
    always @(negedge CLK) begin
        cnt <= (en && cnt < gap - 1) ? cnt + 1 : 0;
        blank_start <= en && cnt < 2;
    end
endmodule : rtu_src_model

// ==== tb.sv ====
// Testbench for the training policy and unplug block
`timescale 1ns/1ps
`include "rtu_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
    typedef struct { logic [31:0] p; int n; logic [1:0] pe; logic [1:0] sw; } rtu_row_t;
    logic        CLK = 1'h0, SYS_RST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0;
    // Lock is held low while iterating, because gaining lock ends the training attempt
    logic        TRAIN_START = 1'h0, TRAIN_ITER = 1'h0, LOCK_ACQUIRED = 1'h0, src_en = 1'h0;
    logic [11:0] REG_ADDR = 12'h0;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
    logic [1:0]  LANE_SWING_SET = 2'h0, PREEMPH_REQ, SWING_REQ;
    logic        BLANK_START_PIN, TRAIN_FAIL, LOCK_TIMEOUT, UNPLUG_IRQ;
    int          n_fail = 0, check_count = 0, cycles = 0, k, irqs;
    // Policy word, iterations, expected pre-emphasis and swing
    rtu_row_t rows [9] = '{'{32'h2000, 3, 2'h2, 2'h3}, '{32'h3000, 1, 2'h1, 2'h1},
        '{32'h1608, 2, 2'h1, 2'h2}, '{32'h3404, 3, 2'h3, 2'h0}, '{32'h3404, 7, 2'h3, 2'h1},
        '{32'h3424, 5, 2'h3, 2'h2}, '{32'h8e4c08, 0, 2'h1, 2'h0}, '{32'h8e4c08, 2, 2'h3, 2'h0},
        '{32'h8e4c08, 6, 2'h2, 2'h0}};
    rtu_top uut (.*);
    rtu_src_model src (.CLK(CLK), .en(src_en), .gap(32'h0000000a), .blank_start(BLANK_START_PIN));
    always #50 CLK = ~CLK;
    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask : cyc
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        cyc(1);
        REG_WR = 1'h1;
        REG_ADDR = a;
        REG_WDATA = d;
        cyc(1);
        REG_WR = 1'h0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        cyc(1);
        REG_RD = 1'h1;
        REG_ADDR = a;
        cyc(1);
        REG_RD = 1'h0;
        `CHK(REG_RDATA, e)
    endtask : rd
    // Start pulse when it is low, iteration pulse when high; a low cycle precedes each
    task automatic pulse(input logic it);
        cyc(1);
        TRAIN_ITER = it;
        TRAIN_START = !it;
        cyc(1);
        TRAIN_ITER = 1'h0;
        TRAIN_START = 1'h0;
    endtask : pulse
    initial begin
        cyc(3);
        SYS_RST = 1'h0;
        rd(`RTU_OFF_POLICY, `RTU_POLICY_RST);
        rd(`RTU_OFF_LOCK, `RTU_LOCK_RST);
        rd(`RTU_OFF_IDLE, `RTU_IDLE_RST);
        wr(12'h300, 32'hffffffff);
        rd(12'h300, 32'h0);
        foreach (rows[i]) begin
            wr(`RTU_OFF_POLICY, rows[i].p);
            pulse(1'h0);
            repeat (rows[i].n) pulse(1'h1);
            `CHK(PREEMPH_REQ, rows[i].pe)
            `CHK(SWING_REQ, rows[i].sw)
        end
        LOCK_ACQUIRED = 1'h0;
        wr(`RTU_OFF_LOCK, 32'h14);
        pulse(1'h0);
        cyc(15);
        `CHK(LOCK_TIMEOUT, 1'h0)
        for (k = 0; k < 10 && LOCK_TIMEOUT !== 1'h1; k++)
            cyc(1);
        `CHK(LOCK_TIMEOUT, 1'h1)
        cyc(2);
        `CHK(TRAIN_FAIL, 1'h1)
        wr(`RTU_OFF_LOCK, 32'h40000014);
        rd(`RTU_OFF_LOCK, 32'h40000014);
        pulse(1'h0);
        cyc(40);
        `CHK(LOCK_TIMEOUT, 1'h0)
        `CHK(TRAIN_FAIL, 1'h0)
        LOCK_ACQUIRED = 1'h1;
        LANE_SWING_SET = 2'h1;
        wr(`RTU_OFF_POLICY, 32'h2);
        pulse(1'h0);
        cyc(3);
        `CHK(TRAIN_FAIL, 1'h1)
        LANE_SWING_SET = 2'h2;
        cyc(3);
        `CHK(TRAIN_FAIL, 1'h0)
        // Bench clock is not the nominal rate, so the limit is rewritten
        wr(`RTU_OFF_IDLE, 32'h1e);
        src_en = 1'h1;
        irqs = 0;
        repeat (200) begin
            cyc(1);
            irqs += UNPLUG_IRQ;
        end
        `CHK(irqs, 0)
        src_en = 1'h0;
        for (k = 0; k < 100 && UNPLUG_IRQ !== 1'h1; k++)
            cyc(1);
        `CHK(UNPLUG_IRQ, 1'h1)
        for (k = 1; k < 100; k++) begin
            cyc(1);
            if (UNPLUG_IRQ === 1'h1)
                break;
        end
        `CHK(k, 31)
        finish_test();
    end
endmodule : tb
